// file: src/idc_pkg.sv
package idc_pkg;
   // ------------------------------------------------------------
   // register map, byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADR_A_LO = 8'h00;
   localparam logic [7:0] ADR_A_HI = 8'h04;
   localparam logic [7:0] ADR_B_LO = 8'h08;
   localparam logic [7:0] ADR_B_HI = 8'h0C;
   localparam logic [7:0] ADR_CMD = 8'h10;
   localparam logic [7:0] ADR_STAT = 8'h14;
   localparam logic [7:0] ADR_RES_LO = 8'h18;
   localparam logic [7:0] ADR_RES_HI = 8'h1C;
   localparam logic [7:0] ADR_CFR = 8'h20;
   localparam logic [7:0] ADR_FXR = 8'h24;
   localparam logic [7:0] ADR_CFG = 8'h28;
   // ------------------------------------------------------------
   // command word layout
   // ------------------------------------------------------------
   localparam int CMD_OP_LSB = 0;
   localparam int OP_W = 4;
   localparam int CMD_RC = 4;
   localparam int CMD_OE = 5;
   localparam int CMD_WIDE = 6;
   localparam int CMD_CRF_LSB = 7;
   localparam int CRF_W = 3;
   localparam int CMD_IMM_LSB = 16;
   localparam int IMM_W = 16;
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_DIVD = 4'h1,
      OP_DIVWU = 4'h2,
      OP_DIVDU = 4'h3,
      OP_CMPI = 4'h4,
      OP_CMP = 4'h5,
      OP_CMPLI = 4'h6,
      OP_CMPL = 4'h7
   } idc_op_t;
   // ------------------------------------------------------------
   // status, exception, config and condition field bits
   // ------------------------------------------------------------
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_INV = 2;
   localparam int FXR_SO = 31;
   localparam int FXR_OF = 30;
   localparam int CFG_NARROW = 0;
   localparam int FLD_LT = 3;
   localparam int FLD_GT = 2;
   localparam int FLD_EQ = 1;
   localparam int FLD_SO = 0;
   localparam int FLD_W = 4;
   localparam int N_FLD = 8;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   localparam logic [6:0] DIV_STEPS = 7'h40;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DIV = 3'b010,
      ST_FIN = 3'b100
   } idc_state_t;
endpackage

// file: src/idc_divider.sv
`timescale 1ns/1ps
module idc_divider (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // request
   input wire logic start,
   input wire logic sgn,
   input wire logic [63:0] dividend,
   input wire logic [63:0] divisor,
   // result
   output logic done,
   output logic [63:0] quot
);
   logic [64:0] rem_q;
   logic [63:0] quo_q;
   logic [63:0] dvs_q;
   logic [6:0] cnt_q;
   logic neg_q;
   logic run_q;
   logic [64:0] shl;
   logic [64:0] diff;
   logic [63:0] abs_a;
   logic [63:0] abs_b;

   // signed operands run through the unsigned core as magnitudes
   assign abs_a = (sgn && dividend[63]) ? 64'(-dividend) : dividend;
   assign abs_b = (sgn && divisor[63]) ? 64'(-divisor) : divisor;
   assign shl = {rem_q[63:0], quo_q[63]};
   assign diff = shl - {1'b0, dvs_q};
   assign quot = neg_q ? 64'(-quo_q) : quo_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rem_q <= 65'h0;
         quo_q <= 64'h0;
         dvs_q <= 64'h0;
         cnt_q <= 7'h0;
         neg_q <= 1'b0;
         run_q <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= run_q && (cnt_q == 7'h1);
         if (start) begin
            rem_q <= 65'h0;
            quo_q <= abs_a;
            dvs_q <= abs_b;
            neg_q <= sgn && (dividend[63] ^ divisor[63]);
            cnt_q <= idc_pkg::DIV_STEPS;
            run_q <= 1'b1;
         end else if (run_q) begin
            // restoring step, one quotient bit per clock
            rem_q <= diff[64] ? shl : diff;
            quo_q <= {quo_q[62:0], ~diff[64]};
            cnt_q <= cnt_q - 7'h1;
            run_q <= cnt_q != 7'h1;
         end
      end
   end
endmodule // idc_divider

// file: src/idc_compare.sv
`timescale 1ns/1ps
module idc_compare (
   // operands
   input wire logic [63:0] src_a,
   input wire logic [63:0] src_b,
   input wire logic [15:0] imm,
   // mode
   input wire logic is_signed,
   input wire logic use_imm,
   input wire logic wide,
   // outcome
   output logic lt,
   output logic gt,
   output logic eq
);
   logic [63:0] opa;
   logic [63:0] opb_reg;
   logic [63:0] opb_imm;
   logic [63:0] opb;

   // narrow mode uses only the low word; for signed compares its top bit is the sign
   assign opa = wide ? src_a : {{32{is_signed & src_a[31]}}, src_a[31:0]};
   assign opb_reg = wide ? src_b : {{32{is_signed & src_b[31]}}, src_b[31:0]};
   assign opb_imm = {{48{is_signed & imm[15]}}, imm};
   assign opb = use_imm ? opb_imm : opb_reg;
   assign eq = opa == opb;
   assign lt = is_signed ? ($signed(opa) < $signed(opb)) : (opa < opb);
   assign gt = !lt && !eq;
endmodule // idc_compare

// file: src/idc_unit.sv
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module idc_unit (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   idc_pkg::idc_state_t state_q;
   idc_pkg::idc_state_t state_d;
   logic [63:0] a_q;
   logic [63:0] b_q;
   logic [31:0] cmd_q;
   logic [63:0] res_q;
   logic [31:0] cf_q;
   logic [31:0] cf_d;
   logic [31:0] fxr_q;
   logic narrow_q;
   logic done_q;
   logic inv_q;
   logic ovf_q;
   logic [31:0] dat_d;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   logic req;
   logic wr;
   logic [31:0] wmask;
   logic [31:0] cmd_n;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // writes land on the edge at which the master sees ack, never before
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   logic wr_alo, wr_ahi, wr_blo, wr_bhi, wr_cmd, wr_cfr, wr_fxr, wr_cfg;
   assign wr_alo = wr && (wb_adr_i == idc_pkg::ADR_A_LO);
   assign wr_ahi = wr && (wb_adr_i == idc_pkg::ADR_A_HI);
   assign wr_blo = wr && (wb_adr_i == idc_pkg::ADR_B_LO);
   assign wr_bhi = wr && (wb_adr_i == idc_pkg::ADR_B_HI);
   assign wr_cmd = wr && (wb_adr_i == idc_pkg::ADR_CMD);
   assign wr_cfr = wr && (wb_adr_i == idc_pkg::ADR_CFR);
   assign wr_fxr = wr && (wb_adr_i == idc_pkg::ADR_FXR);
   assign wr_cfg = wr && (wb_adr_i == idc_pkg::ADR_CFG);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction

   assign cmd_n = merge(cmd_q, wb_dat_i, wmask);

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   logic [3:0] op_n;
   logic [3:0] op_q;
   logic n_is_div, n_is_cmp, n_bad;
   logic idle, start, div_start;
   logic is_div, is_cmp, rc_q, oe_q, wide_q, sgn_cmp, imm_cmp;
   logic [2:0] crf_q;
   assign op_n = cmd_n[idc_pkg::CMD_OP_LSB +: idc_pkg::OP_W];
   assign n_is_div = (op_n == idc_pkg::OP_DIVD) || (op_n == idc_pkg::OP_DIVWU) || (op_n == idc_pkg::OP_DIVDU);
   assign n_is_cmp = (op_n >= idc_pkg::OP_CMPI) && (op_n <= idc_pkg::OP_CMPL);
   assign n_bad = n_is_cmp && cmd_n[idc_pkg::CMD_WIDE] && narrow_q;
   assign idle = state_q == idc_pkg::ST_IDLE;
   // a command written while busy is dropped; status shows busy
   assign start = wr_cmd && idle && (n_is_div || n_is_cmp) && !n_bad;
   assign div_start = start && n_is_div;
   assign op_q = cmd_q[idc_pkg::CMD_OP_LSB +: idc_pkg::OP_W];
   assign is_div = (op_q == idc_pkg::OP_DIVD) || (op_q == idc_pkg::OP_DIVWU) || (op_q == idc_pkg::OP_DIVDU);
   assign is_cmp = (op_q >= idc_pkg::OP_CMPI) && (op_q <= idc_pkg::OP_CMPL);
   assign rc_q = cmd_q[idc_pkg::CMD_RC];
   assign oe_q = cmd_q[idc_pkg::CMD_OE];
   assign wide_q = cmd_q[idc_pkg::CMD_WIDE];
   assign crf_q = cmd_q[idc_pkg::CMD_CRF_LSB +: idc_pkg::CRF_W];
   assign sgn_cmp = (op_q == idc_pkg::OP_CMPI) || (op_q == idc_pkg::OP_CMP);
   assign imm_cmp = (op_q == idc_pkg::OP_CMPI) || (op_q == idc_pkg::OP_CMPLI);

   // ------------------------------------------------------------
   // divide datapath
   // ------------------------------------------------------------
   logic [63:0] dvd;
   logic [63:0] dvs;
   logic div_sgn;
   logic div_done;
   logic [63:0] quot;
   logic ovf_n;
   logic word_op;
   assign word_op = op_n == idc_pkg::OP_DIVWU;
   assign dvd = word_op ? {32'h0000_0000, a_q[31:0]} : a_q;
   assign dvs = word_op ? {32'h0000_0000, b_q[31:0]} : b_q;
   assign div_sgn = op_n == idc_pkg::OP_DIVD;
   assign ovf_n = (dvs == 64'h0000_0000_0000_0000) ||
                  (div_sgn && (a_q == 64'h8000_0000_0000_0000) && (b_q == 64'hFFFF_FFFF_FFFF_FFFF));

   idc_divider u_div (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(div_start),
      .sgn(div_sgn),
      .dividend(dvd),
      .divisor(dvs),
      .done(div_done),
      .quot(quot)
   );

   // ------------------------------------------------------------
   // compare datapath
   // ------------------------------------------------------------
   logic c_lt, c_gt, c_eq;
   idc_compare u_cmp (
      .src_a(a_q),
      .src_b(b_q),
      .imm(cmd_q[idc_pkg::CMD_IMM_LSB +: idc_pkg::IMM_W]),
      .is_signed(sgn_cmp),
      .use_imm(imm_cmp),
      .wide(wide_q),
      .lt(c_lt),
      .gt(c_gt),
      .eq(c_eq)
   );

   // ------------------------------------------------------------
   // commit
   // ------------------------------------------------------------
   logic fin;
   logic [63:0] res_n;
   logic [63:0] res_sx;
   logic so_old, so_n, of_n;
   logic [3:0] cmp_fld;
   logic [3:0] rec_fld;
   logic [31:0] cf_sw;
   logic [31:0] fxr_n;
   assign fin = state_q == idc_pkg::ST_FIN;
   // upper half left zero: any value is allowed there
   assign res_n = (op_q == idc_pkg::OP_DIVWU) ? {32'h0000_0000, quot[31:0]} : quot;
   assign res_sx = (op_q == idc_pkg::OP_DIVWU) ? {{32{quot[31]}}, quot[31:0]} : quot;
   assign so_old = fxr_q[idc_pkg::FXR_SO];
   assign so_n = so_old || (oe_q && ovf_q);
   assign of_n = oe_q ? ovf_q : fxr_q[idc_pkg::FXR_OF];
   assign cmp_fld = {c_lt, c_gt, c_eq, so_old};
   assign rec_fld = {res_sx[63], !res_sx[63] && (res_sx != 64'h0), res_sx == 64'h0, so_n};
   assign cf_sw = wr_cfr ? merge(cf_q, wb_dat_i, wmask) : cf_q;

   // field 0 sits in the top nibble; hardware update wins over a write
   genvar g;
   for (g = 0; g < idc_pkg::N_FLD; g++) begin : g_fld
      logic hit_c, hit_r;
      assign hit_c = fin && is_cmp && (crf_q == 3'(g));
      assign hit_r = fin && is_div && rc_q && (g == 0);
      assign cf_d[(idc_pkg::N_FLD - 1 - g) * idc_pkg::FLD_W +: idc_pkg::FLD_W] =
         hit_c ? cmp_fld : (hit_r ? rec_fld : cf_sw[(idc_pkg::N_FLD - 1 - g) * idc_pkg::FLD_W +: idc_pkg::FLD_W]);
   end

   always_comb begin
      fxr_n = wr_fxr ? merge(fxr_q, wb_dat_i, wmask) : fxr_q;
      if (fin && is_div && oe_q) begin
         fxr_n[idc_pkg::FXR_OF] = of_n;
         fxr_n[idc_pkg::FXR_SO] = so_n;
      end
   end

   always_comb begin
      case (state_q)
         idc_pkg::ST_IDLE: state_d = !start ? idc_pkg::ST_IDLE : (n_is_div ? idc_pkg::ST_DIV : idc_pkg::ST_FIN);
         idc_pkg::ST_DIV: state_d = div_done ? idc_pkg::ST_FIN : idc_pkg::ST_DIV;
         idc_pkg::ST_FIN: state_d = idc_pkg::ST_IDLE;
         default: state_d = idc_pkg::ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always_comb begin
      case (wb_adr_i)
         idc_pkg::ADR_A_LO: dat_d = a_q[31:0];
         idc_pkg::ADR_A_HI: dat_d = a_q[63:32];
         idc_pkg::ADR_B_LO: dat_d = b_q[31:0];
         idc_pkg::ADR_B_HI: dat_d = b_q[63:32];
         idc_pkg::ADR_CMD: dat_d = cmd_q;
         idc_pkg::ADR_STAT: dat_d = {29'h0, inv_q, done_q, !idle};
         idc_pkg::ADR_RES_LO: dat_d = res_q[31:0];
         idc_pkg::ADR_RES_HI: dat_d = res_q[63:32];
         idc_pkg::ADR_CFR: dat_d = cf_q;
         idc_pkg::ADR_FXR: dat_d = fxr_q;
         idc_pkg::ADR_CFG: dat_d = {31'h0, narrow_q};
         default: dat_d = idc_pkg::REG_RST;
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= idc_pkg::REG_RST;
         state_q <= idc_pkg::ST_IDLE;
         cf_q <= idc_pkg::REG_RST;
         fxr_q <= idc_pkg::REG_RST;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? dat_d : idc_pkg::REG_RST;
         state_q <= state_d;
         cf_q <= cf_d;
         fxr_q <= fxr_n;
      end
   end

   // operands are frozen while a command runs
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         a_q <= 64'h0;
         b_q <= 64'h0;
         narrow_q <= 1'b0;
      end else begin
         if (wr_alo && idle) a_q[31:0] <= merge(a_q[31:0], wb_dat_i, wmask);
         if (wr_ahi && idle) a_q[63:32] <= merge(a_q[63:32], wb_dat_i, wmask);
         if (wr_blo && idle) b_q[31:0] <= merge(b_q[31:0], wb_dat_i, wmask);
         if (wr_bhi && idle) b_q[63:32] <= merge(b_q[63:32], wb_dat_i, wmask);
         if (wr_cfg && wb_sel_i[0]) narrow_q <= wb_dat_i[idc_pkg::CFG_NARROW];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_q <= idc_pkg::REG_RST;
         res_q <= 64'h0;
         done_q <= 1'b0;
         inv_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         if (wr_cmd && idle) cmd_q <= cmd_n;
         if (wr_cmd && idle) inv_q <= n_bad;
         if (start) ovf_q <= n_is_div && ovf_n;
         if (fin && is_div) res_q <= res_n;
         done_q <= fin || (done_q && !start);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   logic [3:0] fld_now;
   assign fld_now = cf_q[{~crf_q, 2'b00} +: 4];
   sequence s_fin_cmp;
      fin && is_cmp;
   endsequence
   sequence s_fin_div;
      fin && is_div;
   endsequence

   a_ack_single: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle");
   a_cmp_onehot: assert property (s_fin_cmp |=> $onehot(fld_now[3:1]))
      else $error("compare field not one-hot");
   a_cmp_so_copy: assert property (s_fin_cmp |=> fld_now[0] == $past(so_old))
      else $error("summary overflow not copied");
   a_cmp_others: assert property ((s_fin_cmp and !wr_cfr) |=>
      ((cf_q ^ $past(cf_q)) & ~(32'hF000_0000 >> {$past(crf_q), 2'b00})) == 32'h0)
      else $error("other condition field changed");
   a_norec_keep: assert property ((s_fin_div and !rc_q and !wr_cfr) |=> cf_q == $past(cf_q))
      else $error("condition reg changed without record");
   a_div_latency: assert property (div_start |-> ##[65:66] fin)
      else $error("divide did not finish in time");
   a_ovf_record: assert property ((s_fin_div and oe_q and ovf_q) |=>
      fxr_q[idc_pkg::FXR_OF] && fxr_q[idc_pkg::FXR_SO])
      else $error("overflow not recorded");
   a_bad_form: assert property (wr_cmd && idle && n_bad |=> idle && inv_q ##1 idle)
      else $error("invalid form not refused");
   a_word_hi: assert property (fin && op_q == idc_pkg::OP_DIVWU |=> res_q[63:32] == 32'h0)
      else $error("word quotient high half not zero");

   // ------------------------------------------------------------
   // handshake, hold and sticky checks
   // ------------------------------------------------------------
   // a compare needs no datapath wait, so it enters the commit state on the next edge
   sequence s_go_cmp;
      start && n_is_cmp ##1 fin ##1 (idle && done_q);
   endsequence
   sequence s_go_div;
      div_start ##1 (state_q == idc_pkg::ST_DIV) ##1 !idle;
   endsequence

   a_cmp_start: assert property (start && n_is_cmp |-> s_go_cmp)
      else $error("compare did not commit in two cycles");
   a_div_start: assert property (div_start |-> s_go_div)
      else $error("divide did not enter its run state");
   a_fin_once: assert property (fin |=> !fin)
      else $error("commit state held longer than one cycle");
   a_start_clear: assert property (start |=> !done_q)
      else $error("done not cleared by a new command");
   a_ack_quiet: assert property (!req |=> !wb_ack_o && wb_dat_o == idc_pkg::REG_RST)
      else $error("ack or read data outside a request");
   // the divider latches its operands, but software reads them back
   a_ops_frozen: assert property (!idle |=> $stable(a_q) && $stable(b_q))
      else $error("operand changed while busy");
   a_cmd_drop: assert property (wr_cmd && !idle |=> $stable(cmd_q))
      else $error("command taken while busy");
   a_inv_clear: assert property (wr_cmd && idle && !n_bad |=> !inv_q)
      else $error("invalid flag left set by a valid form");
   a_res_hold: assert property (!fin |=> $stable(res_q))
      else $error("result changed outside commit");
   a_rec_onehot: assert property ((s_fin_div and rc_q) |=> $onehot(cf_q[31:29]))
      else $error("record field not one-hot");
   // a same-cycle software write is excluded, since without the overflow form it would change the register
   a_fxr_keep: assert property ((s_fin_div and !oe_q and !wr_fxr) |=> fxr_q == $past(fxr_q))
      else $error("exception reg changed without overflow form");
   a_ovf_clear: assert property ((s_fin_div and oe_q and !ovf_q) |=> !fxr_q[idc_pkg::FXR_OF])
      else $error("overflow flag not cleared");
   // only software may clear the summary bit
   a_so_sticky: assert property (fxr_q[idc_pkg::FXR_SO] && !wr_fxr |=> fxr_q[idc_pkg::FXR_SO])
      else $error("summary overflow not sticky");
endmodule // idc_unit

// file: testbench/idc_issue_model.sv
`timescale 1ns/1ps
module idc_issue_model (
   // clock
   input wire logic ref_clk,
   // wishbone master side
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [7:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_i
);
   initial begin
      wb_cyc_o = 1'h0;
      wb_stb_o = 1'h0;
      wb_we_o = 1'h0;
      wb_adr_o = 8'h00;
      wb_sel_o = 4'hf;
      wb_dat_o = 32'h0000_0000;
   end
   // ------------------------------------------------------------
   // one classic cycle
   // ------------------------------------------------------------
   // released address and data lines show the inverse so stale data never looks valid
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                       output logic [31:0] rdat, output logic ok);
      int n;
      @(posedge ref_clk);
      wb_cyc_o <= 1'h1;
      wb_stb_o <= 1'h1;
      wb_we_o <= we;
      wb_adr_o <= adr;
      wb_sel_o <= 4'hf;
      wb_dat_o <= wdat;
      ok = 1'h0;
      n = 0;
      rdat = 32'h0000_0000;
      while (ok == 1'h0 && n < 64) begin
         @(posedge ref_clk);
         n++;
         if (wb_ack_i === 1'h1) begin
            ok = 1'h1;
            rdat = wb_dat_i;
         end
      end
      wb_cyc_o <= 1'h0;
      wb_stb_o <= 1'h0;
      wb_we_o <= 1'h0;
      wb_adr_o <= ~adr;
      wb_dat_o <= ~wdat;
   endtask
endmodule // idc_issue_model

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   // ------------------------------------------------------------
   // signals and bookkeeping
   // ------------------------------------------------------------
   logic ref_clk = 1'h0;
   logic rst_n = 1'h0;
   logic wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat, wb_rdat, r, t;
   logic [31:0] cf_m = 32'h0000_0000;
   logic [31:0] fx_m = 32'h0000_0000;
   logic [63:0] a, b;
   logic [15:0] imm;
   logic [7:0] adrs [6] = '{idc_pkg::ADR_STAT, idc_pkg::ADR_CFR, idc_pkg::ADR_FXR, idc_pkg::ADR_RES_LO,
                            idc_pkg::ADR_CFG, 8'h3c};
   int bad_count = 0;
   int cmp_count = 0;
   int seed = 78235;
   always #4 ref_clk = ~ref_clk;
   idc_unit idc_unit_i (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack));
   idc_issue_model idc_issue_model_i (.ref_clk(ref_clk), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
      .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .wb_dat_i(wb_rdat),
      .wb_ack_i(wb_ack));
   // ------------------------------------------------------------
   // checking and bus helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic bus(input logic we, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
      logic ok;
      idc_issue_model_i.xfer(we, ad, d, q, ok);
      if (ok !== 1'h1) begin
         bad_count++;
         wrap_up();
      end
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      r = 32'h0000_0000;
      while (!(r[idc_pkg::STAT_DONE] === 1'h1 && r[idc_pkg::STAT_BUSY] === 1'h0) && n < 100) begin
         bus(1'h0, idc_pkg::ADR_STAT, 32'h0000_0000, r);
         n++;
      end
      if (r[idc_pkg::STAT_DONE] !== 1'h1) begin
         bad_count++;
         wrap_up();
      end
   endtask
   // operand rewrite during a divide must be dropped while busy
   task automatic run(input idc_pkg::idc_op_t op, input logic rc, input logic oe, input logic w,
                      input logic [2:0] fld, input logic [15:0] k, input logic [63:0] x, input logic [63:0] y);
      bus(1'h1, idc_pkg::ADR_A_LO, x[31:0], r);
      bus(1'h1, idc_pkg::ADR_A_HI, x[63:32], r);
      bus(1'h1, idc_pkg::ADR_B_LO, y[31:0], r);
      bus(1'h1, idc_pkg::ADR_B_HI, y[63:32], r);
      bus(1'h1, idc_pkg::ADR_CMD, {k, 6'h00, fld, w, oe, rc, op}, r);
      if (op inside {idc_pkg::OP_DIVD, idc_pkg::OP_DIVWU, idc_pkg::OP_DIVDU}) begin
         bus(1'h1, idc_pkg::ADR_A_LO, ~x[31:0], r);
         bus(1'h0, idc_pkg::ADR_A_LO, 32'h0000_0000, r);
         chk(r, x[31:0]);
      end
      wait_done();
   endtask
   // ------------------------------------------------------------
   // reference model
   // ------------------------------------------------------------
   function automatic logic [2:0] cmp_exp(input idc_pkg::idc_op_t op, input logic w, input logic [63:0] x,
                                          input logic [63:0] y, input logic [15:0] k);
      logic s;
      s = (op == idc_pkg::OP_CMPI || op == idc_pkg::OP_CMP);
      if (op == idc_pkg::OP_CMPI) y = {{48{k[15]}}, k};
      if (op == idc_pkg::OP_CMPLI) y = {48'h0000_0000_0000, k};
      if (!w) begin
         x = s ? {{32{x[31]}}, x[31:0]} : {32'h0000_0000, x[31:0]};
         if (op == idc_pkg::OP_CMP || op == idc_pkg::OP_CMPL) y = s ? {{32{y[31]}}, y[31:0]} : {32'h0000_0000, y[31:0]};
      end
      if (x == y) return 3'h1;
      if (s ? ($signed(x) < $signed(y)) : (x < y)) return 3'h4;
      return 3'h2;
   endfunction
   task automatic cmp_case(input idc_pkg::idc_op_t op, input logic w, input logic [2:0] fld,
                           input logic [15:0] k, input logic [63:0] x, input logic [63:0] y);
      logic [2:0] c;
      c = cmp_exp(op, w, x, y, k);
      run(op, 1'h0, 1'h0, w, fld, k, x, y);
      cf_m[31 - 4 * int'(fld) -: 4] = {c, fx_m[31]};
      bus(1'h0, idc_pkg::ADR_CFR, 32'h0000_0000, r);
      chk(r, cf_m);
   endtask
   // overflowed quotient is unspecified, so its record form is not asked for
   task automatic div_case(input idc_pkg::idc_op_t op, input logic rc, input logic oe,
                           input logic [63:0] x, input logic [63:0] y);
      logic [63:0] q, s;
      logic ovf;
      q = 64'h0000_0000_0000_0000;
      if (op == idc_pkg::OP_DIVWU) begin
         ovf = (y[31:0] == 32'h0000_0000);
         if (!ovf) q = {32'h0000_0000, x[31:0] / y[31:0]};
         s = {{32{q[31]}}, q[31:0]};
      end else begin
         ovf = (y == 64'h0000_0000_0000_0000) || (op == idc_pkg::OP_DIVD &&
               x == 64'h8000_0000_0000_0000 && y == 64'hffff_ffff_ffff_ffff);
         if (!ovf && op == idc_pkg::OP_DIVD) q = $signed(x) / $signed(y);
         if (!ovf && op == idc_pkg::OP_DIVDU) q = x / y;
         s = q;
      end
      if (ovf) rc = 1'h0;
      run(op, rc, oe, 1'h0, 3'h0, 16'h0000, x, y);
      if (oe) begin
         fx_m[30] = ovf;
         fx_m[31] = fx_m[31] | ovf;
      end
      if (rc) cf_m[31:28] = {$signed(s) < 0, $signed(s) > 0, s == 64'h0000_0000_0000_0000, fx_m[31]};
      if (!ovf) begin
         bus(1'h0, idc_pkg::ADR_RES_LO, 32'h0000_0000, r);
         chk(r, q[31:0]);
         if (op != idc_pkg::OP_DIVWU) begin
            bus(1'h0, idc_pkg::ADR_RES_HI, 32'h0000_0000, r);
            chk(r, q[63:32]);
         end
      end
      bus(1'h0, idc_pkg::ADR_CFR, 32'h0000_0000, r);
      chk(r, cf_m);
      bus(1'h0, idc_pkg::ADR_FXR, 32'h0000_0000, r);
      chk(r & 32'hc000_0000, fx_m);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'h1;
      bus(1'h1, idc_pkg::ADR_STAT, 32'hffff_ffff, r);
      bus(1'h1, 8'h3c, 32'hffff_ffff, r);
      foreach (adrs[i]) begin
         bus(1'h0, adrs[i], 32'h0000_0000, r);
         chk(r, 32'h0000_0000);
      end
      for (int i = 0; i < 48; i++) begin
         if (i % 16 == 0) begin
            fx_m = {i[4], 31'h0000_0000};
            bus(1'h1, idc_pkg::ADR_FXR, fx_m, r);
         end
         a = {$random(seed), $random(seed)};
         b = {$random(seed), $random(seed)};
         t = $random(seed);
         imm = t[31:16];
         if (i % 3 == 0) begin
            a[63:16] = {48{a[15]}};
            imm = a[15:0];
            b = a;
         end
         if (i % 6 == 3) b = {~a[63:32], a[31:0]};
         cmp_case(idc_pkg::idc_op_t'(4 + i % 4), t[0], t[3:1], imm, a, b);
      end
      bus(1'h1, idc_pkg::ADR_CFG, 32'h0000_0001, r);
      bus(1'h1, idc_pkg::ADR_CMD, {16'h0000, 6'h00, 3'h5, 1'h1, 2'h0, idc_pkg::OP_CMP}, r);
      bus(1'h0, idc_pkg::ADR_STAT, 32'h0000_0000, r);
      chk(r & 32'h0000_0005, 32'h0000_0004);
      bus(1'h0, idc_pkg::ADR_CFR, 32'h0000_0000, r);
      chk(r, cf_m);
      cmp_case(idc_pkg::OP_CMPI, 1'h0, 3'h7, 16'h8000, 64'h1234_5678_ffff_8000, 64'h0000_0000_0000_0000);
      bus(1'h1, idc_pkg::ADR_CFG, 32'h0000_0000, r);
      div_case(idc_pkg::OP_DIVD, 1'h1, 1'h1, 64'h8000_0000_0000_0000, 64'hffff_ffff_ffff_ffff);
      div_case(idc_pkg::OP_DIVDU, 1'h0, 1'h1, 64'h0000_0000_0000_0007, 64'h0000_0000_0000_0000);
      div_case(idc_pkg::OP_DIVWU, 1'h0, 1'h1, 64'h0000_0000_0000_0005, 64'hffff_ffff_0000_0000);
      div_case(idc_pkg::OP_DIVD, 1'h1, 1'h0, 64'hffff_ffff_ffff_fff9, 64'h0000_0000_0000_0002);
      for (int i = 0; i < 24; i++) begin
         t = $random(seed);
         a = {$random(seed), $random(seed)};
         b = {$random(seed), $random(seed)};
         div_case(idc_pkg::idc_op_t'(1 + i % 3), t[0], t[1], a, b >> t[7:2]);
      end
      wrap_up();
   end
endmodule // testbench
